// *** art16_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module art16_counter #(
	parameter int unsigned CNT_W = art16_pkg::CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Count enable and reload value
	input wire logic tick,
	input wire logic [CNT_W-1:0] reload,
	// State
	output logic [CNT_W-1:0] count,
	output logic overflow
);
	// Rollover happens on a tick at all ones
	assign overflow = tick && (count == {CNT_W{1'b1}});

	// Up counter with automatic reload
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (overflow) begin
			count <= reload;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end
endmodule : art16_counter
`default_nettype wire

// *** art16_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module art16_monitor (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Interrupts and baud
	input wire logic SERVICE_ENTRY,
	input wire logic TIMER_IRQ,
	input wire logic IRQ,
	input wire logic BAUD_TICK
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Committed control write that clears the run bit
	sequence s_halt;
		PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PWDATA[3]
			&& PADDR == 12'h310;
	endsequence
	a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("No ready after setup");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("Ready held too long");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("Error without ready");
	a_byte_wide: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
		else $error("Upper read data not zero");
	a_misalign_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0
		|=> PSLVERR) else $error("Misaligned access accepted");
	// Service entry with no bus commit and no rollover at that edge
	sequence s_service;
		SERVICE_ENTRY && !PSEL ##1 !BAUD_TICK;
	endsequence
	a_reset_quiet: assert property ($rose(RST_N) |->
		!IRQ && !TIMER_IRQ && !BAUD_TICK)
		else $error("Output active after reset");
	a_halt_quiet: assert property (s_halt |=> ##1 !BAUD_TICK [*8])
		else $error("Overflow while halted");
	a_service_clr: assert property (s_service |-> ##1 !TIMER_IRQ)
		else $error("Flag not cleared on service entry");
endmodule : art16_monitor
bind art16_timer art16_monitor u_art16_monitor (.REF_CLK(REF_CLK),
	.RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SERVICE_ENTRY(SERVICE_ENTRY),
	.TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ), .BAUD_TICK(BAUD_TICK));
`default_nettype wire

// *** art16_pkg.sv ***
`default_nettype none
package art16_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [11:0] IDX_CTRL = 12'h0c4;
	localparam logic [11:0] IDX_RELOAD_LO = 12'h0c5;
	localparam logic [11:0] IDX_RELOAD_HI = 12'h0c6;
	localparam logic [11:0] IDX_COUNT_LO = 12'h0c7;
	localparam logic [11:0] IDX_COUNT_HI = 12'h0c8;
	localparam logic [11:0] IDX_IRQ_EN = 12'h0c9;
	localparam logic [11:0] IDX_STATUS = 12'h0ca;
	localparam logic [11:0] IDX_MASK = 12'h0cb;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned CNT_W = 16;
	// Control register fields
	localparam int unsigned PS_W = 3;
	localparam int unsigned PS_LSB = 0;
	localparam int unsigned RUN_BIT = 3;
	localparam int unsigned OVF_BIT = 4;
	localparam int unsigned UPPER_LSB = 5;
	localparam int unsigned UPPER_W = 3;
	// Prescaler divider width: 2**7 = divide by 128 at the top code
	localparam int unsigned DIV_W = 7;
	// Timer interrupt enable bit inside the extended enable register
	localparam int unsigned TIMER_IE_BIT = 1;
	// Status / mask layout
	localparam int unsigned STAT_W = 2;
	localparam int unsigned STAT_OVF = 0;
	localparam int unsigned STAT_BADWR = 1;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Register selected by an APB address
	typedef enum logic [3:0] {
		SEL_NONE, SEL_CTRL, SEL_RELOAD_LO, SEL_RELOAD_HI, SEL_COUNT_LO,
		SEL_COUNT_HI, SEL_IRQ_EN, SEL_STATUS, SEL_MASK
	} art16_sel_e;
endpackage : art16_pkg
`default_nettype wire

// *** art16_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module art16_prescaler #(
	parameter int unsigned PS_W = art16_pkg::PS_W,
	parameter int unsigned DIV_W = art16_pkg::DIV_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic [PS_W-1:0] sel,
	// Count enable for the counter
	output logic tick
);
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] low_mask;

	// Free divider, held at zero while halted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= '0;
		end else if (!run) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// Code n ticks once every 2**n clocks
	always_comb begin
		low_mask = DIV_W'((DIV_W+1)'(1) << sel) - 1'b1;
		tick = run && ((div | ~low_mask) == {DIV_W{1'b1}});
	end
endmodule : art16_prescaler
`default_nettype wire

// *** art16_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module art16_timer (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [art16_pkg::ADDR_W-1:0] PADDR,
	input wire logic [art16_pkg::DATA_W-1:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [art16_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Processor interrupt handshake
	input wire logic SERVICE_ENTRY,
	output logic TIMER_IRQ,
	// Block interrupt
	output logic IRQ,
	// Baud clock source for the serial ports
	output logic BAUD_TICK
);
	// Control register state
	logic [art16_pkg::UPPER_W-1:0] ctrl_upper;
	logic overflow_flag;
	logic run_control;
	logic [art16_pkg::PS_W-1:0] prescale_select;
	// Reload bytes and interrupt enable register
	logic [art16_pkg::BYTE_W-1:0] reload_low;
	logic [art16_pkg::BYTE_W-1:0] reload_high;
	logic [art16_pkg::BYTE_W-1:0] ext_irq_enable_reg;
	// Sticky status and its mask
	logic [art16_pkg::STAT_W-1:0] status;
	logic [art16_pkg::STAT_W-1:0] mask;
	// Status bits returned by the read in flight
	logic [art16_pkg::STAT_W-1:0] read_snap;
	// Datapath
	logic tick;
	logic overflow;
	logic [art16_pkg::CNT_W-1:0] count;
	// Bus decode
	art16_pkg::art16_sel_e setup_sel;
	art16_pkg::art16_sel_e access_sel;
	logic setup;
	logic access_done;
	logic wr;
	logic wr_lane0;
	logic [art16_pkg::BYTE_W-1:0] wbyte;
	logic [art16_pkg::BYTE_W-1:0] ctrl_view;
	logic [art16_pkg::BYTE_W-1:0] read_byte;
	logic timer_irq_enable;
	logic bad_reload_write;
	logic [art16_pkg::STAT_W-1:0] status_set;
	// Per-register write strobes for the committing access
	logic wr_ctrl;
	logic wr_reload_lo;
	logic wr_reload_hi;
	logic wr_irq_en;
	logic wr_mask;

	// Maps a byte address onto a register; misaligned or unknown is none
	function automatic art16_pkg::art16_sel_e art16_decode(
		input logic [art16_pkg::ADDR_W-1:0] addr
	);
		logic [art16_pkg::ADDR_W-1:0] a;
		a = addr >> 2;
		if (addr[1:0] != 2'b00) begin
			art16_decode = art16_pkg::SEL_NONE;
		end else if (a == art16_pkg::IDX_CTRL) begin
			art16_decode = art16_pkg::SEL_CTRL;
		end else if (a == art16_pkg::IDX_RELOAD_LO) begin
			art16_decode = art16_pkg::SEL_RELOAD_LO;
		end else if (a == art16_pkg::IDX_RELOAD_HI) begin
			art16_decode = art16_pkg::SEL_RELOAD_HI;
		end else if (a == art16_pkg::IDX_COUNT_LO) begin
			art16_decode = art16_pkg::SEL_COUNT_LO;
		end else if (a == art16_pkg::IDX_COUNT_HI) begin
			art16_decode = art16_pkg::SEL_COUNT_HI;
		end else if (a == art16_pkg::IDX_IRQ_EN) begin
			art16_decode = art16_pkg::SEL_IRQ_EN;
		end else if (a == art16_pkg::IDX_STATUS) begin
			art16_decode = art16_pkg::SEL_STATUS;
		end else if (a == art16_pkg::IDX_MASK) begin
			art16_decode = art16_pkg::SEL_MASK;
		end else begin
			art16_decode = art16_pkg::SEL_NONE;
		end
	endfunction : art16_decode

	// Prescaler feeding the counter
	art16_prescaler #(
		.PS_W(art16_pkg::PS_W),
		.DIV_W(art16_pkg::DIV_W)
	) u_prescaler (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.run(run_control),
		.sel(prescale_select),
		.tick(tick)
	);

	// Reload counter, low byte in bits 7:0 and high byte above
	art16_counter #(
		.CNT_W(art16_pkg::CNT_W)
	) u_counter (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.tick(tick),
		.reload({reload_high, reload_low}),
		.count(count),
		.overflow(overflow)
	);

	// Bus phase and write qualifiers
	always_comb begin
		setup = PSEL && !PENABLE;
		access_done = PSEL && PENABLE && PREADY;
		wr = access_done && PWRITE;
		wr_lane0 = wr && PSTRB[0];
		wbyte = PWDATA[art16_pkg::BYTE_W-1:0];
		setup_sel = art16_decode(PADDR);
		access_sel = art16_decode(PADDR);
		timer_irq_enable = ext_irq_enable_reg[art16_pkg::TIMER_IE_BIT];
	end

	// Control register as software sees it
	always_comb begin
		ctrl_view = {ctrl_upper, overflow_flag, run_control,
			prescale_select};
	end

	// Read mux, evaluated in the setup cycle
	always_comb begin
		read_byte = art16_pkg::RST_BYTE;
		case (setup_sel)
			art16_pkg::SEL_CTRL: read_byte = ctrl_view;
			art16_pkg::SEL_RELOAD_LO: read_byte = reload_low;
			art16_pkg::SEL_RELOAD_HI: read_byte = reload_high;
			art16_pkg::SEL_COUNT_LO: read_byte = count[7:0];
			art16_pkg::SEL_COUNT_HI: read_byte = count[15:8];
			art16_pkg::SEL_IRQ_EN: read_byte = ext_irq_enable_reg;
			art16_pkg::SEL_STATUS: read_byte = {6'h00, status};
			art16_pkg::SEL_MASK: read_byte = {6'h00, mask};
			default: read_byte = art16_pkg::RST_BYTE;
		endcase
	end

	// Per-register write strobes, true only on the committing edge
	always_comb begin
		wr_ctrl = wr_lane0 && (access_sel == art16_pkg::SEL_CTRL);
		wr_reload_lo = wr_lane0 &&
			(access_sel == art16_pkg::SEL_RELOAD_LO);
		wr_reload_hi = wr_lane0 &&
			(access_sel == art16_pkg::SEL_RELOAD_HI);
		wr_irq_en = wr_lane0 && (access_sel == art16_pkg::SEL_IRQ_EN);
		wr_mask = wr_lane0 && (access_sel == art16_pkg::SEL_MASK);
	end

	// Ready answers every setup in the following cycle, no wait states
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
		end else if (setup) begin
			PREADY <= 1'b1;
		end else begin
			PREADY <= 1'b0;
		end
	end

	// Error answers an unmapped or misaligned address together with ready
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PSLVERR <= (setup_sel == art16_pkg::SEL_NONE);
		end else begin
			PSLVERR <= 1'b0;
		end
	end

	// Read data is captured at setup and held until the next setup
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= art16_pkg::RST_WORD;
		end else if (setup) begin
			PRDATA <= PWRITE ? art16_pkg::RST_WORD
				: {24'h000000, read_byte};
		end
	end

	// Status bits handed to a status read, so later sets are not lost
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			read_snap <= '0;
		end else if (setup) begin
			read_snap <= (!PWRITE && setup_sel == art16_pkg::SEL_STATUS)
				? status : '0;
		end else begin
			read_snap <= '0;
		end
	end

	// Run control; halting also parks the prescaler divider
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			run_control <= 1'b0;
		end else if (wr_ctrl) begin
			run_control <= wbyte[art16_pkg::RUN_BIT];
		end
	end

	// Prescale code for the divider
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prescale_select <= '0;
		end else if (wr_ctrl) begin
			prescale_select <= wbyte[art16_pkg::PS_LSB +: art16_pkg::PS_W];
		end
	end

	// Upper control bits, stored for software with no effect here
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_upper <= '0;
		end else if (wr_ctrl) begin
			ctrl_upper <= wbyte[art16_pkg::UPPER_LSB +: art16_pkg::UPPER_W];
		end
	end

	// Overflow flag: hardware set beats any clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			overflow_flag <= 1'b0;
		end else if (overflow) begin
			overflow_flag <= 1'b1;
		end else if (wr_ctrl) begin
			overflow_flag <= wbyte[art16_pkg::OVF_BIT];
		end else if (SERVICE_ENTRY) begin
			overflow_flag <= 1'b0;
		end
	end

	// Reload low byte; a write while running is kept but flagged
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			reload_low <= art16_pkg::RST_BYTE;
		end else if (wr_reload_lo) begin
			reload_low <= wbyte;
		end
	end

	// Reload high byte; a write while running is kept but flagged
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			reload_high <= art16_pkg::RST_BYTE;
		end else if (wr_reload_hi) begin
			reload_high <= wbyte;
		end
	end

	// Reload write during counting, surfaced as a status event
	always_comb begin
		bad_reload_write = run_control &&
			(wr_reload_lo || wr_reload_hi);
		status_set = '0;
		status_set[art16_pkg::STAT_OVF] = overflow;
		status_set[art16_pkg::STAT_BADWR] = bad_reload_write;
	end

	// Extended interrupt enable register; bit 1 gates the timer request
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ext_irq_enable_reg <= art16_pkg::RST_BYTE;
		end else if (wr_irq_en) begin
			ext_irq_enable_reg <= wbyte;
		end
	end

	// Mask of the status bits that may raise the block interrupt
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask <= '0;
		end else if (wr_mask) begin
			mask <= wbyte[art16_pkg::STAT_W-1:0];
		end
	end

	// Sticky status; a read clears only what it returned, new sets win
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			status <= '0;
		end else if (access_done && !PWRITE) begin
			status <= (status & ~read_snap) | status_set;
		end else begin
			status <= status | status_set;
		end
	end

	// Timer interrupt request, one cycle behind the flag
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			TIMER_IRQ <= 1'b0;
		end else begin
			TIMER_IRQ <= overflow_flag && timer_irq_enable;
		end
	end

	// Block interrupt, high while an unmasked status bit is set
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask);
		end
	end

	// Baud clock pulse, one per counter rollover
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			BAUD_TICK <= 1'b0;
		end else begin
			BAUD_TICK <= overflow;
		end
	end
endmodule : art16_timer
`default_nettype wire

// *** art16_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module art16_timer_tb;
	localparam logic [11:0] CTL = art16_pkg::IDX_CTRL;
	localparam logic [11:0] RLO = art16_pkg::IDX_RELOAD_LO;
	localparam logic [11:0] RHI = art16_pkg::IDX_RELOAD_HI;
	localparam logic [11:0] CLO = art16_pkg::IDX_COUNT_LO;
	localparam logic [11:0] STA = art16_pkg::IDX_STATUS;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, svc = 0;
	logic [11:0] paddr = 12'h0;
	logic [3:0] strb = 4'hf;
	logic [31:0] pwdata = 32'h0, prdata, rd, keep;
	logic pready, pslverr, tirq, irq, baud, err;
	int n_fail = 0, tests_run = 0, cyc = 0;
	// Clock
	always #12.5 clk = ~clk;
	art16_timer u_art16_timer (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(strb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SERVICE_ENTRY(svc), .TIMER_IRQ(tirq), .IRQ(irq), .BAUD_TICK(baud));
	task wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One APB transfer, held until ready is sampled at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] i, input logic [7:0] d);
		apb(1'b1, i << 2, d);
	endtask : wr
	task rchk(input logic [11:0] i, input logic [31:0] e);
		apb(1'b0, i << 2, 8'h0);
		chk(rd, e);
	endtask : rchk
	task cycles(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cycles
	// Reset values, byte lanes and refused addresses
	task t_regs;
		rchk(CTL, 32'h0);
		rchk(CLO, 32'h0);
		wr(RLO, 8'h5a);
		wr(RHI, 8'ha5);
		rchk(RLO, 32'h5a);
		rchk(RHI, 32'ha5);
		strb <= 4'he;
		wr(RLO, 8'h33);
		strb <= 4'hf;
		rchk(RLO, 32'h5a);
		apb(1'b0, 12'h311, 8'h0);
		chk(err, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h3f0, 8'hff);
		chk(err, 32'h1);
	endtask : t_regs
	// Overflow period for every prescale code, then interrupt paths
	task t_period;
		int n;
		wr(art16_pkg::IDX_IRQ_EN, 8'h02);
		for (int ps = 0; ps < 8; ps++) begin
			wr(CTL, 8'h00);
			wr(RLO, 8'hfe);
			wr(RHI, 8'hff);
			wr(CTL, 8'h08 + 8'(ps));
			@(negedge clk);
			while (baud !== 1'b1) @(negedge clk);
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (baud !== 1'b1);
			chk(n, 32'(2 << ps));
		end
		rchk(CTL, 32'h1f);
		chk(tirq, 32'h1);
		chk(irq, 32'h0);
		wr(art16_pkg::IDX_MASK, 8'h01);
		cycles(2);
		chk(irq, 32'h1);
		wr(CTL, 8'h10);
		apb(1'b0, CLO << 2, 8'h0);
		keep = rd;
		cycles(20);
		rchk(CLO, keep);
		rchk(STA, 32'h1);
		cycles(2);
		chk(irq, 32'h0);
	endtask : t_period
	// Flag cleared by service entry, forced by software
	task t_flag;
		@(posedge clk);
		svc <= 1'b1;
		@(posedge clk);
		svc <= 1'b0;
		cycles(2);
		chk(tirq, 32'h0);
		rchk(CTL, 32'h0);
		wr(CTL, 8'h10);
		cycles(2);
		chk(tirq, 32'h1);
		wr(CTL, 8'h00);
		cycles(2);
		chk(tirq, 32'h0);
	endtask : t_flag
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			wrap_up;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_period;
		t_flag;
		wrap_up;
	end
endmodule : art16_timer_tb
`default_nettype wire
